// *** hdl/sfe_pkg.sv ***
// shared constants and types for the serial flash erase link
package sfe_pkg;

  ////////////////////////////////////////////////////////////////////
  // command codes, shifted msb first
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_FULL_ERASE   = 8'hC7;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;

  ////////////////////////////////////////////////////////////////////
  // frame lengths in bits
  localparam int         CNT_W        = 6;
  localparam logic [5:0] BITS_OPCODE  = 6'h08;
  localparam logic [5:0] BITS_STATUS  = 6'h10;
  localparam logic [5:0] BITS_ADDRESS = 6'h20;
  localparam logic [5:0] CNT_MAX      = 6'h3F;
  localparam int         ADDR_W       = 24;

  ////////////////////////////////////////////////////////////////////
  // status byte layout and reset values
  localparam int   STAT_WIP   = 0;
  localparam int   STAT_WEL   = 1;
  localparam logic WIP_RESET  = 1'b0;
  localparam logic WEL_RESET  = 1'b0;
  localparam logic BLANK_INIT = 1'b1;

  ////////////////////////////////////////////////////////////////////
  // times and derived cycle counts at mclk
  localparam longint MCLK_HZ             = 200000000;
  localparam longint SECTOR_ERASE_TIME_MS = 2000;
  localparam longint FULL_ERASE_TIME_MS   = 17000;
  localparam longint CS_HIGH_TIME_NS      = 100;
  localparam longint SCLK_PERIOD_NS       = 80;
  localparam longint SECTOR_ERASE_CYC =
    SECTOR_ERASE_TIME_MS * MCLK_HZ / 1000;
  localparam longint FULL_ERASE_CYC =
    FULL_ERASE_TIME_MS * MCLK_HZ / 1000;
  localparam longint CS_HIGH_CYC =
    (CS_HIGH_TIME_NS * MCLK_HZ + 999999999) / 1000000000;
  localparam longint SCLK_HALF_CYC =
    SCLK_PERIOD_NS * MCLK_HZ / 2000000000;

  ////////////////////////////////////////////////////////////////////
  // host jobs and states
  typedef enum logic [1:0] {
    SFE_JOB_SECTOR,
    SFE_JOB_FULL,
    SFE_JOB_STATUS
  } sfe_job_t;

  typedef enum logic [1:0] {
    SFE_H_IDLE,
    SFE_H_SHIFT,
    SFE_H_GAP
  } sfe_host_state_t;

  typedef enum logic [1:0] {
    SFE_STEP_WREN,
    SFE_STEP_ERASE,
    SFE_STEP_POLL,
    SFE_STEP_READ
  } sfe_step_t;

endpackage

// *** hdl/sfe_link_if.sv ***
// serial link between the flash erase host and the flash device
`timescale 1ns/1ps
interface sfe_link_if;
  logic serial_clock;
  logic chip_select_n;
  logic serial_cmd_in;
  logic serial_data_out;

  modport dev (
    input  serial_clock,
    input  chip_select_n,
    input  serial_cmd_in,
    output serial_data_out
  );

  modport host (
    output serial_clock,
    output chip_select_n,
    output serial_cmd_in,
    input  serial_data_out
  );
endinterface

// *** hdl/sfe_device.sv ***
// flash device end: command shifter, erase sequencer, status
`timescale 1ns/1ps

// Notes on behaviour
// - sector erase code D8, msb first
// - erased sector reads all ones
// - host issues write enable before erase
// - sector erase: code then three address bytes
// - any address inside sector selects it
// - host raises select only on byte boundary
// - erase starts as select rises
// - busy bit high during sector erase
// - busy bit high during full erase
// - write enable latch cleared before finish
// - host waits or polls until not busy
// - address bits above capacity ignored
// - full erase code C7, eight bits only
module sfe_device #(
  parameter int          ADDR_BITS   = 24,
  parameter int          SECTOR_BITS = 16,
  parameter logic [31:0] SECTOR_CYC  =
    32'(sfe_pkg::SECTOR_ERASE_CYC),
  parameter logic [31:0] FULL_CYC    =
    32'(sfe_pkg::FULL_ERASE_CYC)
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  sfe_link_if.dev                     link,
  input  wire logic                   mark_used_i,
  input  wire logic [ADDR_BITS-SECTOR_BITS-1:0] mark_sector_i,
  output logic                        wip_o,
  output logic                        wel_o,
  output logic                        erase_done_o,
  output logic [(1<<(ADDR_BITS-SECTOR_BITS))-1:0] blank_o,
  output logic [7:0]                  erase_fill_o
);

  localparam int IDX_W = ADDR_BITS - SECTOR_BITS;
  localparam int NSEC  = 1 << IDX_W;

  //////////////////////////////////////////////////////////////////////
  // command match on a finished frame
  function automatic logic is_cmd(
    input logic [5:0]  cnt,
    input logic [31:0] sh,
    input logic [7:0]  op,
    input logic [5:0]  len
  );
    logic [7:0] code;
    code = (len == sfe_pkg::BITS_OPCODE) ? sh[7:0] : sh[31:24];
    return (cnt == len) && (code == op);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // link domain: shifter runs on the host's serial clock
  logic        wip;
  logic        wel;
  logic        fresh;
  logic [5:0]  cnt;
  logic [31:0] sh;
  logic [5:0]  next_cnt;
  logic [31:0] next_sh;
  logic        wip_l1;
  logic        wip_l2;
  logic        wel_l1;
  logic        wel_l2;
  logic [7:0]  so_sh;
  logic [7:0]  next_so_sh;

  // first edge of a frame restarts the bit count
  always_ff @(posedge link.serial_clock or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    if (fresh) begin
      next_cnt = 6'h01;
    end else if (cnt == sfe_pkg::CNT_MAX) begin
      next_cnt = cnt;
    end else begin
      next_cnt = cnt + 6'h01;
    end
    next_sh = {sh[30:0], link.serial_cmd_in};
  end

  // count and shifter hold after the frame for the mclk side
  always_ff @(posedge link.serial_clock) begin
    cnt    <= next_cnt;
    sh     <= next_sh;
    wip_l1 <= wip;
    wip_l2 <= wip_l1;
    wel_l1 <= wel;
    wel_l2 <= wel_l1;
  end

  // status byte leaves on falling edges after the read code
  always_comb begin
    if (is_cmd(cnt, sh, sfe_pkg::OP_READ_STATUS, sfe_pkg::BITS_OPCODE)) begin
      next_so_sh = 8'h00;
      next_so_sh[sfe_pkg::STAT_WIP] = wip_l2;
      next_so_sh[sfe_pkg::STAT_WEL] = wel_l2;
    end else begin
      next_so_sh = {so_sh[6:0], 1'b0};
    end
  end

  always_ff @(negedge link.serial_clock or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      so_sh <= 8'h00;
    end else begin
      so_sh <= next_so_sh;
    end
  end

  assign link.serial_data_out = so_sh[7];

  //////////////////////////////////////////////////////////////////////
  // mclk domain: select edge and erase sequencing
  logic             cs_s1;
  logic             cs_s2;
  logic             cs_q;
  logic             cs_rise;
  logic             full;
  logic [IDX_W-1:0] sel;
  logic [31:0]      timer;
  logic [NSEC-1:0]  blank;
  logic             done;
  logic             next_wip;
  logic             next_wel;
  logic             next_full;
  logic [IDX_W-1:0] next_sel;
  logic [31:0]      next_timer;
  logic [NSEC-1:0]  next_blank;
  logic             next_done;
  logic             go_wren;
  logic             go_sector;
  logic             go_full;

  // a rising select makes the frame words stable for sampling
  assign cs_rise = cs_s2 & ~cs_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_q  <= 1'b1;
    end else begin
      cs_s1 <= link.chip_select_n;
      cs_s2 <= cs_s1;
      cs_q  <= cs_s2;
    end
  end

  always_comb begin
    go_wren   = cs_rise & ~wip &
      is_cmd(cnt, sh, sfe_pkg::OP_WRITE_ENABLE, sfe_pkg::BITS_OPCODE);
    go_sector = cs_rise & ~wip & wel &
      is_cmd(cnt, sh, sfe_pkg::OP_SECTOR_ERASE, sfe_pkg::BITS_ADDRESS);
    go_full   = cs_rise & ~wip & wel &
      is_cmd(cnt, sh, sfe_pkg::OP_FULL_ERASE, sfe_pkg::BITS_OPCODE);
  end

  always_comb begin
    next_wip   = wip;
    next_wel   = wel;
    next_full  = full;
    next_sel   = sel;
    next_timer = timer;
    next_blank = blank;
    next_done  = 1'b0;
    if (mark_used_i) begin
      next_blank[mark_sector_i] = 1'b0;
    end
    if (wip) begin
      if (timer == 32'h0000_0000) begin
        next_wip  = 1'b0;
        next_done = 1'b1;
        if (full) begin
          next_blank = {NSEC{1'b1}};
        end else begin
          next_blank[sel] = 1'b1;
        end
      end else begin
        next_timer = timer - 32'h0000_0001;
      end
    end else if (go_wren) begin
      next_wel = 1'b1;
    end else if (go_sector || go_full) begin
      next_wip   = 1'b1;
      next_wel   = 1'b0;
      next_full  = go_full;
      // upper bits beyond the part's size never reach the index
      next_sel   = sh[ADDR_BITS-1:SECTOR_BITS];
      next_timer = go_full ? FULL_CYC - 32'h0000_0001
                           : SECTOR_CYC - 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wip   <= sfe_pkg::WIP_RESET;
      wel   <= sfe_pkg::WEL_RESET;
      full  <= 1'b0;
      sel   <= '0;
      timer <= 32'h0000_0000;
      blank <= {NSEC{sfe_pkg::BLANK_INIT}};
      done  <= 1'b0;
    end else begin
      wip   <= next_wip;
      wel   <= next_wel;
      full  <= next_full;
      sel   <= next_sel;
      timer <= next_timer;
      blank <= next_blank;
      done  <= next_done;
    end
  end

  assign wip_o        = wip;
  assign wel_o        = wel;
  assign erase_done_o = done;
  assign blank_o      = blank;
  assign erase_fill_o = sfe_pkg::ERASED_BYTE;

endmodule

// *** hdl/sfe_host.sv ***
// host end: runs write enable, erase and status polling frames
`timescale 1ns/1ps
module sfe_host #(
  parameter logic [3:0] HALF_CYC = 4'(sfe_pkg::SCLK_HALF_CYC),
  parameter logic [4:0] GAP_CYC  = 5'(sfe_pkg::CS_HIGH_CYC)
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  sfe_link_if.host              link,
  input  wire logic             job_valid_i,
  output logic                  job_ready_o,
  input  wire sfe_pkg::sfe_job_t job_kind_i,
  input  wire logic [23:0]      job_addr_i,
  output logic                  job_done_o,
  output logic [7:0]            status_o
);

  function automatic logic [31:0] frame(
    input logic [7:0]  op,
    input logic [23:0] adr
  );
    return {op, adr};
  endfunction

  //////////////////////////////////////////////////////////////////////
  sfe_pkg::sfe_host_state_t state, next_state;
  sfe_pkg::sfe_step_t       step, next_step;
  sfe_pkg::sfe_job_t        kind, next_kind;
  logic [23:0] addr, next_addr;
  logic [31:0] tx, next_tx;
  logic [5:0]  nbits, next_nbits;
  logic [3:0]  div, next_div;
  logic [4:0]  gap, next_gap;
  logic [7:0]  rx, next_rx;
  logic [7:0]  status, next_status;
  logic        sclk, next_sclk;
  logic        cs_n, next_cs_n;
  logic        mosi, next_mosi;
  logic        done, next_done;
  logic        miso_s1;
  logic        miso_s2;
  logic        launch;
  logic [31:0] l_word;
  logic [5:0]  l_bits;

  always_comb begin
    next_state  = state;
    next_step   = step;
    next_kind   = kind;
    next_addr   = addr;
    next_tx     = tx;
    next_nbits  = nbits;
    next_div    = div;
    next_gap    = gap;
    next_rx     = rx;
    next_status = status;
    next_sclk   = sclk;
    next_cs_n   = cs_n;
    next_mosi   = mosi;
    next_done   = 1'b0;
    launch      = 1'b0;
    l_word      = frame(sfe_pkg::OP_READ_STATUS, 24'h000000);
    l_bits      = sfe_pkg::BITS_STATUS;
    unique case (state)
      sfe_pkg::SFE_H_IDLE: begin
        if (job_valid_i) begin
          next_kind = job_kind_i;
          next_addr = job_addr_i;
          launch    = 1'b1;
          if (job_kind_i == sfe_pkg::SFE_JOB_STATUS) begin
            next_step = sfe_pkg::SFE_STEP_READ;
          end else begin
            next_step = sfe_pkg::SFE_STEP_WREN;
            l_word = frame(sfe_pkg::OP_WRITE_ENABLE, 24'h000000);
            l_bits = sfe_pkg::BITS_OPCODE;
          end
        end
      end
      sfe_pkg::SFE_H_SHIFT: begin
        if (div == HALF_CYC - 4'h1) begin
          next_div  = 4'h0;
          next_sclk = ~sclk;
          if (!sclk) begin
            next_rx    = {rx[6:0], miso_s2};
            next_nbits = nbits - 6'h01;
          end else if (nbits == 6'h00) begin
            next_cs_n  = 1'b1;
            next_gap   = 5'h00;
            next_state = sfe_pkg::SFE_H_GAP;
          end else begin
            next_tx   = {tx[30:0], 1'b0};
            next_mosi = tx[30];
          end
        end else begin
          next_div = div + 4'h1;
        end
      end
      sfe_pkg::SFE_H_GAP: begin
        if (gap == GAP_CYC - 5'h01) begin
          unique case (step)
            sfe_pkg::SFE_STEP_WREN: begin
              launch    = 1'b1;
              next_step = sfe_pkg::SFE_STEP_ERASE;
              if (kind == sfe_pkg::SFE_JOB_FULL) begin
                l_word = frame(sfe_pkg::OP_FULL_ERASE, 24'h000000);
                l_bits = sfe_pkg::BITS_OPCODE;
              end else begin
                l_word = frame(sfe_pkg::OP_SECTOR_ERASE, addr);
                l_bits = sfe_pkg::BITS_ADDRESS;
              end
            end
            sfe_pkg::SFE_STEP_ERASE: begin
              launch    = 1'b1;
              next_step = sfe_pkg::SFE_STEP_POLL;
            end
            sfe_pkg::SFE_STEP_POLL: begin
              if (rx[sfe_pkg::STAT_WIP]) begin
                launch = 1'b1;
              end else begin
                next_status = rx;
                next_done   = 1'b1;
                next_state  = sfe_pkg::SFE_H_IDLE;
              end
            end
            sfe_pkg::SFE_STEP_READ: begin
              next_status = rx;
              next_done   = 1'b1;
              next_state  = sfe_pkg::SFE_H_IDLE;
            end
          endcase
        end else begin
          next_gap = gap + 5'h01;
        end
      end
      default: begin
        next_state = sfe_pkg::SFE_H_IDLE;
      end
    endcase
    if (launch) begin
      next_tx    = l_word;
      next_mosi  = l_word[31];
      next_nbits = l_bits;
      next_div   = 4'h0;
      next_sclk  = 1'b0;
      next_cs_n  = 1'b0;
      next_state = sfe_pkg::SFE_H_SHIFT;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state   <= sfe_pkg::SFE_H_IDLE;
      step    <= sfe_pkg::SFE_STEP_READ;
      kind    <= sfe_pkg::SFE_JOB_STATUS;
      addr    <= 24'h000000;
      tx      <= 32'h0000_0000;
      nbits   <= 6'h00;
      div     <= 4'h0;
      gap     <= 5'h00;
      rx      <= 8'h00;
      status  <= 8'h00;
      sclk    <= 1'b0;
      cs_n    <= 1'b1;
      mosi    <= 1'b0;
      done    <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      state   <= next_state;
      step    <= next_step;
      kind    <= next_kind;
      addr    <= next_addr;
      tx      <= next_tx;
      nbits   <= next_nbits;
      div     <= next_div;
      gap     <= next_gap;
      rx      <= next_rx;
      status  <= next_status;
      sclk    <= next_sclk;
      cs_n    <= next_cs_n;
      mosi    <= next_mosi;
      done    <= next_done;
      miso_s1 <= link.serial_data_out;
      miso_s2 <= miso_s1;
    end
  end

  assign link.serial_clock  = sclk;
  assign link.chip_select_n = cs_n;
  assign link.serial_cmd_in = mosi;
  assign job_ready_o        = (state == sfe_pkg::SFE_H_IDLE);
  assign job_done_o         = done;
  assign status_o           = status;

endmodule

// *** verif/sfe_link_asserts.sv ***
// checker on the host to device link and the device status outputs
`timescale 1ns/1ps
module sfe_link_asserts #(
  parameter logic [31:0] FULL_CYC = 32'h50
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_cmd_in,
  input wire logic serial_data_out,
  input wire logic wip_o,
  input wire logic wel_o,
  input wire logic erase_done_o
);
  logic        sclk_q;
  logic [5:0]  bits, next_bits;
  logic [7:0]  op, next_op;
  logic [2:0]  age, next_age;
  logic [31:0] run, next_run;
  ////////////////////////////////////////
  // frame bit count, first byte, cycles since select rose, busy span
  always_comb begin
    next_bits = chip_select_n ? 6'h00 : bits;
    next_op = op;
    if (!chip_select_n && serial_clock && !sclk_q) begin
      if (bits < 6'h08) next_op = {op[6:0], serial_cmd_in};
      if (bits != 6'h3F) next_bits = bits + 6'h01;
    end
    next_age = !chip_select_n ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
    next_run = wip_o ? run + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      bits <= 6'h00;
      op <= 8'h00;
      age <= 3'h7;
      run <= 32'h0;
    end else begin
      sclk_q <= serial_clock;
      bits <= next_bits;
      op <= next_op;
      age <= next_age;
      run <= next_run;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence wel_low_s; (!wel_o)[*8]; endsequence
  sequence wip_high_s; wip_o[*8]; endsequence
  dout_idle_a: assert property (chip_select_n |-> !serial_data_out)
    else $error("data out active while deselected");
  clk_idle_a: assert property (chip_select_n |-> !serial_clock)
    else $error("link clock runs while deselected");
  cs_byte_a: assert property ($rose(chip_select_n) |-> bits[2:0] == 3'h0)
    else $error("select raised off a byte boundary");
  erase_op_a: assert property ($rose(wip_o) |-> op == 8'hD8 || op == 8'hC7)
    else $error("erase started by a wrong code");
  wel_needed_a: assert property ($rose(wip_o) |-> $past(wel_o))
    else $error("erase started without write enable");
  start_cs_a: assert property ($rose(wip_o) |-> age >= 3'h1 && age <= 3'h6)
    else $error("erase start not tied to select rise");
  wel_clear_a: assert property ($rose(wip_o) |-> wel_low_s)
    else $error("write enable latch not cleared");
  wip_hold_a: assert property ($rose(wip_o) |=> wip_high_s)
    else $error("busy dropped early");
  done_end_a: assert property (erase_done_o |-> $fell(wip_o))
    else $error("done not at end of busy");
  wip_bound_a: assert property (run <= FULL_CYC)
    else $error("busy longer than full erase");
endmodule

// *** verif/serial_flash_erase_ops_bench.sv ***
// bench joining host and device, plus a rule breaking driver on a second device
`timescale 1ns/1ps
module serial_flash_erase_ops_bench;
  localparam logic [31:0] SEC = 32'h32;
  localparam logic [31:0] FUL = 32'h200;
  logic              mclk_i, rst_i, job_valid, job_ready, job_done, mark;
  logic              wip, wel, wip_x, wel_x, edone;
  sfe_pkg::sfe_job_t job_kind;
  logic [23:0]       job_addr;
  logic [7:0]        status, fill, sect;
  logic [255:0]      blank;
  logic [63:0]       blank_x;
  int                n_fail, samples_checked, wip_cyc;
  sfe_link_if link ();
  sfe_link_if link_x ();
  sfe_host sfe_host_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(link.host),
    .job_valid_i(job_valid), .job_ready_o(job_ready), .job_kind_i(job_kind),
    .job_addr_i(job_addr), .job_done_o(job_done), .status_o(status));
  sfe_device #(.SECTOR_CYC(SEC), .FULL_CYC(FUL)) sfe_device_i (.mclk_i(mclk_i),
    .rst_i(rst_i), .link(link.dev), .mark_used_i(mark), .mark_sector_i(sect),
    .wip_o(wip), .wel_o(wel), .erase_done_o(edone), .blank_o(blank), .erase_fill_o(fill));
  sfe_device #(.ADDR_BITS(22), .SECTOR_CYC(SEC), .FULL_CYC(FUL)) sfe_device_x_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .link(link_x.dev), .mark_used_i(mark),
    .mark_sector_i(sect[5:0]), .wip_o(wip_x), .wel_o(wel_x), .erase_done_o(),
    .blank_o(blank_x), .erase_fill_o());
  sfe_link_asserts #(.FULL_CYC(FUL)) sfe_link_asserts_i (.mclk_i(mclk_i),
    .rst_i(rst_i), .serial_clock(link.serial_clock),
    .chip_select_n(link.chip_select_n), .serial_cmd_in(link.serial_cmd_in),
    .serial_data_out(link.serial_data_out), .wip_o(wip), .wel_o(wel),
    .erase_done_o(edone));
  ////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (wip === 1'b1) wip_cyc++;
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic job(input sfe_pkg::sfe_job_t k, input logic [23:0] a);
    int n;
    job_kind = k;
    job_addr = a;
    job_valid = 1'b1;
    tk(1);
    job_valid = 1'b0;
    chk("ready taken", 0, job_ready);
    n = 0;
    while (job_done !== 1'b1 && n < 20000) begin
      tk(1);
      n++;
    end
    chk("job done", 1, job_done);
    chk("ready idle", 1, job_ready);
  endtask
  task automatic mk(input logic [7:0] s);
    sect = s;
    mark = 1'b1;
    tk(1);
    mark = 1'b0;
    tk(1);
  endtask
  // msb first frame on the second link, select raised after last falling edge
  task automatic send(input logic [31:0] v, input int n);
    link_x.chip_select_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      link_x.serial_cmd_in = v[i];
      #40 link_x.serial_clock = 1'b1;
      #40 link_x.serial_clock = 1'b0;
    end
    link_x.chip_select_n = 1'b1;
    link_x.serial_cmd_in = ~v[0];
    // select stays high 24 cycles, a little beyond the 20 cycle minimum gap between frames
    tk(24);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk("wip", 0, wip);
    chk("wel", 0, wel);
    chk("blank", '1, blank);
    chk("fill", 8'hFF, fill);
  endtask
  task automatic t_sector;
    mk(8'h12);
    mk(8'h13);
    wip_cyc = 0;
    job(sfe_pkg::SFE_JOB_SECTOR, 24'h12ABCD);
    chk("erased", 1, blank[8'h12]);
    chk("neighbour", 0, blank[8'h13]);
    chk("wip span", SEC, wip_cyc);
    chk("status", 8'h00, status);
  endtask
  task automatic t_full;
    mk(8'h03);
    mk(8'hFE);
    wip_cyc = 0;
    job(sfe_pkg::SFE_JOB_FULL, 24'h000000);
    chk("all blank", '1, blank);
    chk("wip span", FUL, wip_cyc);
    job(sfe_pkg::SFE_JOB_STATUS, 24'h000000);
    chk("status", 8'h00, status);
  endtask
  task automatic t_fault;
    mk(8'h05);
    send(32'hD8C51234, 32);
    chk("no latch", 0, wip_x);
    send(32'h00000006, 8);
    chk("wel set", 1, wel_x);
    send(32'h6C62891A, 31);
    chk("short frame", 0, wip_x);
    chk("wel kept", 1, wel_x);
    chk("kept", 0, blank_x[5]);
    send(32'hD8C51234, 32);
    chk("erasing", 1, wip_x);
    chk("wel cleared", 0, wel_x);
    tk(60);
    chk("finished", 0, wip_x);
    chk("erased", 1, blank_x[5]);
  endtask
  task automatic close_out;
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    n_fail = 0;
    samples_checked = 0;
    wip_cyc = 0;
    rst_i = 1'b1;
    job_valid = 1'b0;
    job_kind = sfe_pkg::SFE_JOB_STATUS;
    job_addr = 24'h000000;
    mark = 1'b0;
    sect = 8'h00;
    link_x.serial_clock = 1'b0;
    link_x.chip_select_n = 1'b1;
    link_x.serial_cmd_in = 1'b0;
    tk(3);
    rst_i = 1'b0;
    tk(3);
    t_reset;
    t_sector;
    t_full;
    t_fault;
    close_out;
  end
  initial begin
    #400000;
    n_fail++;
    close_out;
  end
endmodule
